/* File: core/smbus_bit_capture.sv */
// link-side bit capture, clocked by the bus clock itself
// assumes scl_in only toggles while a frame runs; the reader sees byte_out stable
// for a whole scl period after each bit_toggle_out change
`timescale 1ns/1ps
module smbus_bit_capture
(
   input  wire logic       scl_in,
   input  wire logic       rst_b_in,
   input  wire logic       sda_in,
   output logic [7:0]      byte_out,
   output logic            bit_toggle_out
);

   typedef struct packed
   {
      logic [7:0] shift;
      logic       toggle;
   } capture_s;

   capture_s s;
   capture_s next_s;

   // ----------------------------------------------------------------
   // sample on the rising clock edge, where data is stable
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s        = s;
      next_s.shift  = {s.shift[6:0], sda_in};
      next_s.toggle = ~s.toggle;
   end

   always_ff @(posedge scl_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign byte_out       = s.shift;
   assign bit_toggle_out = s.toggle;

endmodule

/* File: core/smbus_register_access_slave.sv */
// smbus slave front end: address pointer, ram, eeprom cells, identification bytes
// assumes the bus clock low phase spans over three clk_in periods, the high phase over two
//
// Overview of operation
// - first byte after address in a write loads the address pointer, unless it is the block write command 0xfc.
// - two 512-byte eeprom cells sit at 0xf800 to 0xfbff, read and write.
// - one cell holds configuration, the other holds sequencer state definitions.
// - eeprom bytes are written only when blank; master erases first.
// - configuration cell has sixteen pages of 32 bytes.
// - pages zero to six hold configuration; eeprom address is f8 plus ram address.
// - page seven reserved; pages eight to fifteen free for user storage.
// - power-up copies configuration pages zero to six into ram.
// - writing bit 0 at offset 0xd8 repeats the configuration copy.
// - slave only; bus access restricted during the 1 ms download.
// - slave address is 01011 followed by the two select pins.
// - read-only identification bytes at offsets 0xf4 to 0xf7.
// - start is sda falling with scl high, then address and direction.
// - matching address is acknowledged by sda low through the ninth clock.
// - nine clocks per byte; sda changes only while scl low.
// - first write byte is a command: block write or register address.
// - device leaves sda released while the master acknowledges read data.
// - no acknowledge to any access before the download completes.
// - command byte 0xfc announces a block write.
`timescale 1ns/1ps
module smbus_register_access_slave
#(
   parameter int DOWNLOAD_CYCLES = smbus_slave_pkg::DOWNLOAD_CYCLES
)
(
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       address_select_high_pin_in,
   input  wire logic       address_select_low_pin_in,
   input  wire logic [8:0] state_sequencer_addr_in,
   output logic [7:0]      state_sequencer_data_out,
   output logic            download_done_out
);

   localparam int PU_W = $clog2(DOWNLOAD_CYCLES + 1);

   typedef enum logic [2:0]
   {
      st_idle,
      st_addr,
      st_cmd,
      st_ptr_low,
      st_count,
      st_wdata,
      st_rdata,
      st_skip
   } phase_e;

   typedef struct packed
   {
      logic            scl_s1;
      logic            scl_s2;
      logic            scl_d;
      logic            sda_s1;
      logic            sda_s2;
      logic            sda_d;
      logic            tog_s1;
      logic            tog_s2;
      logic            tog_d;
      logic [1:0]      sel_s1;
      logic [1:0]      sel_s2;
      phase_e          st;
      logic [3:0]      cnt;
      logic [15:0]     ptr;
      logic [7:0]      tx;
      logic            ack_pend;
      logic            sda_low;
      logic            blk;
      logic [7:0]      rem;
      logic            reload;
      logic            dl_active;
      logic [7:0]      dl_idx;
      logic [PU_W-1:0] pu_cnt;
      logic [7:0]      seq_data;
   } slave_s;

   slave_s      s;
   slave_s      next_s;
   logic [7:0]  link_byte;
   logic        link_toggle;
   logic        ram_we;
   logic [7:0]  ram_wa;
   logic [7:0]  ram_wd;
   logic        eep_we;
   logic [9:0]  eep_wa;
   logic [7:0]  eep_wd;
   logic        start_ev;
   logic        stop_ev;
   logic        bit_ev;
   logic        fall_ev;
   logic        busy;

   logic [7:0]  ram    [0:smbus_slave_pkg::RAM_BYTES-1];
   logic [7:0]  eeprom [0:smbus_slave_pkg::EEPROM_BYTES-1];

   // ----------------------------------------------------------------
   // link side
   // ----------------------------------------------------------------
   smbus_bit_capture u_capture
   (
      .scl_in         (scl_in),
      .rst_b_in       (rst_b_in),
      .sda_in         (sda_in),
      .byte_out       (link_byte),
      .bit_toggle_out (link_toggle)
   );

   // ----------------------------------------------------------------
   // register space decode
   // ----------------------------------------------------------------
   function automatic logic is_eeprom(input logic [15:0] a);
      is_eeprom = (a >= smbus_slave_pkg::EEPROM_BASE) && (a <= smbus_slave_pkg::EEPROM_TOP);
   endfunction

   function automatic logic [7:0] read_byte(input logic [15:0] a);
      read_byte = smbus_slave_pkg::UNMAPPED_BYTE;
      if (is_eeprom(a))
      begin
         read_byte = eeprom[a[9:0]];
      end
      else if (a[15:8] == 8'h00)
      begin
         unique case (a[7:0])
            smbus_slave_pkg::RELOAD_OFS:       read_byte = {7'h00, s.reload};
            smbus_slave_pkg::MAKER_OFS:        read_byte = smbus_slave_pkg::MAKER_VALUE;
            smbus_slave_pkg::REVISION_OFS:     read_byte = smbus_slave_pkg::REVISION_VALUE;
            smbus_slave_pkg::BRAND_FIRST_OFS:  read_byte = smbus_slave_pkg::BRAND_FIRST_VALUE;
            smbus_slave_pkg::BRAND_SECOND_OFS: read_byte = smbus_slave_pkg::BRAND_SECOND_VALUE;
            default:
            begin
               if (a[7:0] <= smbus_slave_pkg::RAM_TOP_OFS)
               begin
                  read_byte = ram[a[7:0]];
               end
            end
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s    = s;
      ram_we    = 1'b0;
      ram_wa    = 8'h00;
      ram_wd    = 8'h00;
      eep_we    = 1'b0;
      eep_wa    = 10'h000;
      eep_wd    = 8'h00;
      // only the second stage of each synchroniser and, for scl, sda and the toggle, its delayed copy (the third stage) are looked at
      next_s.scl_s1 = scl_in;
      next_s.scl_s2 = s.scl_s1;
      next_s.scl_d  = s.scl_s2;
      next_s.sda_s1 = sda_in;
      next_s.sda_s2 = s.sda_s1;
      next_s.sda_d  = s.sda_s2;
      next_s.tog_s1 = link_toggle;
      next_s.tog_s2 = s.tog_s1;
      next_s.tog_d  = s.tog_s2;
      next_s.sel_s1 = {address_select_high_pin_in, address_select_low_pin_in};
      next_s.sel_s2 = s.sel_s1;
      start_ev = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
      stop_ev  = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;
      bit_ev   = s.tog_s2 ^ s.tog_d;
      fall_ev  = s.scl_d && !s.scl_s2;
      busy     = s.dl_active || (s.pu_cnt != '0);
      next_s.seq_data = eeprom[{1'b1, state_sequencer_addr_in}];
      if (s.pu_cnt != '0)
      begin
         next_s.pu_cnt = s.pu_cnt - 1'b1;
      end

      if (bit_ev && s.st != st_idle)
      begin
         next_s.cnt = s.cnt + 4'd1;
         if (s.cnt == smbus_slave_pkg::BITS_PER_BYTE - 4'd1)
         begin
            unique case (s.st)
               st_addr:
               begin
                  // a busy device stays silent, so the master sees no acknowledge
                  if (link_byte[7:1] == {smbus_slave_pkg::SLAVE_ADDR_FIXED, s.sel_s2} && !busy)
                  begin
                     next_s.ack_pend = 1'b1;
                     if (link_byte[0])
                     begin
                        next_s.st = st_rdata;
                        next_s.tx = read_byte(s.ptr);
                     end
                     else
                     begin
                        next_s.st = st_cmd;
                     end
                  end
                  else
                  begin
                     next_s.st = st_skip;
                  end
               end
               st_cmd:
               begin
                  next_s.ack_pend = 1'b1;
                  next_s.blk      = 1'b0;
                  if (link_byte == smbus_slave_pkg::BLOCK_WRITE_CMD)
                  begin
                     next_s.blk = 1'b1;
                     next_s.st  = st_count;
                  end
                  else if (link_byte[7:2] == smbus_slave_pkg::EEPROM_HIGH_PREFIX)
                  begin
                     next_s.ptr[15:8] = link_byte;
                     next_s.st        = st_ptr_low;
                  end
                  else
                  begin
                     next_s.ptr = {8'h00, link_byte};
                     next_s.st  = st_wdata;
                  end
               end
               st_ptr_low:
               begin
                  next_s.ack_pend = 1'b1;
                  next_s.ptr[7:0] = link_byte;
                  next_s.st       = st_wdata;
               end
               st_count:
               begin
                  next_s.ack_pend = 1'b1;
                  next_s.rem      = link_byte;
                  next_s.st       = st_wdata;
               end
               st_wdata:
               begin
                  next_s.ack_pend = 1'b1;
                  if (!s.blk || s.rem != 8'h00)
                  begin
                     next_s.ptr = s.ptr + 16'd1;
                     if (s.blk)
                     begin
                        next_s.rem = s.rem - 8'd1;
                     end
                     if (is_eeprom(s.ptr))
                     begin
                        // programming only ever clears bits; a used byte needs an erase first
                        eep_we = (eeprom[s.ptr[9:0]] == smbus_slave_pkg::BLANK_BYTE)
                                 && !(s.ptr[9:5] == smbus_slave_pkg::RESERVED_PAGE);
                        eep_wa = s.ptr[9:0];
                        eep_wd = link_byte;
                     end
                     else if (s.ptr == {8'h00, smbus_slave_pkg::RELOAD_OFS})
                     begin
                        next_s.reload = link_byte[smbus_slave_pkg::RELOAD_BIT];
                        if (link_byte[smbus_slave_pkg::RELOAD_BIT])
                        begin
                           next_s.dl_active = 1'b1;
                           next_s.dl_idx    = 8'h00;
                        end
                     end
                     else if (s.ptr[15:8] == 8'h00 && s.ptr[7:0] <= smbus_slave_pkg::RAM_TOP_OFS)
                     begin
                        ram_we = 1'b1;
                        ram_wa = s.ptr[7:0];
                        ram_wd = link_byte;
                     end
                  end
               end
               default:
               begin
               end
            endcase
         end
         else if (s.cnt == smbus_slave_pkg::BITS_PER_BYTE && s.st == st_rdata && !s.ack_pend)
         begin
            // the acknowledge bit from the master is the last bit shifted in;
            // our own acknowledge of the read address must not advance the pointer
            next_s.ptr = s.ptr + 16'd1;
            next_s.tx  = read_byte(s.ptr + 16'd1);
            if (link_byte[0])
            begin
               next_s.st = st_skip;
            end
         end
      end

      if (fall_ev)
      begin
         if (s.cnt == smbus_slave_pkg::BITS_PER_BYTE)
         begin
            next_s.sda_low = s.ack_pend;
         end
         else if (s.cnt == smbus_slave_pkg::ACK_BIT)
         begin
            next_s.cnt      = 4'd0;
            next_s.ack_pend = 1'b0;
            next_s.sda_low  = (s.st == st_rdata) && !s.tx[7];
         end
         else if (s.st == st_rdata && s.cnt != 4'd0)
         begin
            next_s.sda_low = !s.tx[3'd7 - s.cnt[2:0]];
         end
         else
         begin
            next_s.sda_low = 1'b0;
         end
      end

      if (start_ev || stop_ev)
      begin
         next_s.st       = start_ev ? st_addr : st_idle;
         next_s.cnt      = 4'd0;
         next_s.ack_pend = 1'b0;
         next_s.sda_low  = 1'b0;
      end

      // the copy owns the ram port; the bus is refused while it runs
      if (s.dl_active)
      begin
         ram_we = 1'b1;
         ram_wa = s.dl_idx;
         ram_wd = eeprom[{2'b00, s.dl_idx}];
         if (s.dl_idx == smbus_slave_pkg::LAST_CONFIG_BYTE)
         begin
            next_s.dl_active = 1'b0;
            next_s.reload    = 1'b0;
         end
         else
         begin
            next_s.dl_idx = s.dl_idx + 8'd1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s           <= '0;
         s.st        <= st_idle;
         s.scl_s1    <= 1'b1;
         s.scl_s2    <= 1'b1;
         s.scl_d     <= 1'b1;
         s.sda_s1    <= 1'b1;
         s.sda_s2    <= 1'b1;
         s.sda_d     <= 1'b1;
         s.dl_active <= 1'b1;
         s.pu_cnt    <= PU_W'(DOWNLOAD_CYCLES);
      end
      else
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // storage; the eeprom starts blank
   // ----------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < smbus_slave_pkg::EEPROM_BYTES; i++)
      begin
         eeprom[i] = smbus_slave_pkg::BLANK_BYTE;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (ram_we)
      begin
         ram[ram_wa] <= ram_wd;
      end
   end

   // the eeprom keeps an initial image, so its write port is a plain clocked block
   always @(posedge clk_in)
   begin
      if (eep_we)
      begin
         eeprom[eep_wa] <= eep_wd;
      end
   end

   assign sda_out                  = 1'b0;
   assign sda_oe_out               = s.sda_low;
   assign state_sequencer_data_out = s.seq_data;
   assign download_done_out        = !busy;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence addr_byte_done;
      bit_ev && s.st == st_addr && s.cnt == 4'd7;
   endsequence

   sequence reload_write;
      bit_ev && s.st == st_wdata && s.cnt == 4'd7 && !s.blk
         && s.ptr == {8'h00, smbus_slave_pkg::RELOAD_OFS} && link_byte[0];
   endsequence

   a_busy_nack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      addr_byte_done and busy |=> s.st == st_skip && !s.ack_pend)
      else $error("address accepted while download busy");

   a_addr_match_ack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      addr_byte_done and (!busy && link_byte[7:1] == {smbus_slave_pkg::SLAVE_ADDR_FIXED, s.sel_s2}) |=> s.ack_pend)
      else $error("own address not acknowledged");

   a_ptr_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      bit_ev && s.st == st_cmd && s.cnt == 4'd7 && link_byte != 8'hfc && link_byte[7:2] != 6'h3e
      |=> s.ptr == {8'h00, $past(link_byte)} && s.st == st_wdata)
      else $error("command byte did not load pointer");

   a_block_cmd: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      bit_ev && s.st == st_cmd && s.cnt == 4'd7 && link_byte == 8'hfc |=> s.st == st_count && s.blk)
      else $error("block write command not recognised");

   a_eeprom_blank: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      eep_we |-> eeprom[eep_wa] == 8'hff && eep_wa[9:5] != 5'd7)
      else $error("eeprom write to used or reserved byte");

   a_reload_copy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      reload_write and !s.dl_active |=> s.dl_active && s.dl_idx == 8'h00 ##223 s.dl_active ##1 !s.dl_active)
      else $error("reload copy wrong length");

   a_sda_change_low: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $changed(sda_oe_out) |-> !s.scl_d || $past(start_ev || stop_ev))
      else $error("sda drive changed while scl high");

   a_start_frame: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_ev |=> s.st == st_addr && s.cnt == 4'd0 && !sda_oe_out)
      else $error("start did not open a frame");

   a_read_release: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      fall_ev && s.st == st_rdata && s.cnt == 4'd8 && !s.ack_pend |=> !sda_oe_out)
      else $error("device drives master acknowledge slot");

endmodule

/* File: core/smbus_slave_pkg.sv */
// constants for the smbus register access slave: offsets, codes, timing
// assumes a 125 MHz system clock; used by the slave top only through scoped names
package smbus_slave_pkg;

   // ----------------------------------------------------------------
   // register space
   // ----------------------------------------------------------------
   localparam logic [7:0]  RAM_TOP_OFS        = 8'hdf;
   localparam int          RAM_BYTES          = 224;
   localparam logic [7:0]  RELOAD_OFS         = 8'hd8;
   localparam int          RELOAD_BIT         = 0;
   localparam logic [7:0]  MAKER_OFS          = 8'hf4;
   localparam logic [7:0]  REVISION_OFS       = 8'hf5;
   localparam logic [7:0]  BRAND_FIRST_OFS    = 8'hf6;
   localparam logic [7:0]  BRAND_SECOND_OFS   = 8'hf7;
   localparam logic [15:0] EEPROM_BASE        = 16'hf800;
   localparam logic [15:0] EEPROM_TOP         = 16'hfbff;
   localparam logic [5:0]  EEPROM_HIGH_PREFIX = 6'h3e;
   localparam int          EEPROM_BYTES       = 1024;
   localparam int          CELL_BYTES         = 512;
   localparam logic [7:0]  CONFIG_PREFIX      = 8'hf8;
   localparam logic [7:0]  BLANK_BYTE         = 8'hff;
   localparam logic [7:0]  UNMAPPED_BYTE      = 8'h00;

   // ----------------------------------------------------------------
   // page layout of the configuration cell
   // ----------------------------------------------------------------
   localparam int          PAGE_BYTES         = 32;
   localparam int          CONFIG_PAGES       = 7;
   localparam logic [4:0]  RESERVED_PAGE      = 5'd7;
   localparam logic [7:0]  LAST_CONFIG_BYTE   = 8'(CONFIG_PAGES * PAGE_BYTES - 1);

   // ----------------------------------------------------------------
   // bus codes
   // ----------------------------------------------------------------
   localparam logic [4:0]  SLAVE_ADDR_FIXED   = 5'b01011;
   localparam logic [7:0]  BLOCK_WRITE_CMD    = 8'hfc;
   localparam logic [3:0]  BITS_PER_BYTE      = 4'd8;
   localparam logic [3:0]  ACK_BIT            = 4'd9;

   // ----------------------------------------------------------------
   // identification values, arbitrary
   // ----------------------------------------------------------------
   localparam logic [7:0]  MAKER_VALUE        = 8'h3c;
   localparam logic [7:0]  REVISION_VALUE     = 8'h11;
   localparam logic [7:0]  BRAND_FIRST_VALUE  = 8'h7e;
   localparam logic [7:0]  BRAND_SECOND_VALUE = 8'h81;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          CLK_FREQ_KHZ       = 125000;
   localparam int          DOWNLOAD_TIME_US   = 1000;
   localparam int          DOWNLOAD_CYCLES    = DOWNLOAD_TIME_US * CLK_FREQ_KHZ / 1000;

endpackage

/* File: verif/smbus_master_model.sv */
// smbus master model: makes the bus clock and drives data as open drain
// assumes the bench resolves the data wire and feeds it back on sda_in
`timescale 1ns/1ps
module smbus_master_model
(
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   // ------------------------------------------------
   // 48 ns bus clock; low phase 28 ns so the slave's synchronised drive settles before the rise
   // ------------------------------------------------
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic bit_io(input logic b, output logic r);
      #16 sda_out = b;
      #12 scl_out = 1'b1;
      #12 r = sda_in;
      #8 scl_out = 1'b0;
   endtask

   task automatic start_c();
      #24 sda_out = 1'b0;
      #24 scl_out = 1'b0;
   endtask

   task automatic stop_c();
      #16 sda_out = 1'b0;
      #12 scl_out = 1'b1;
      #12 sda_out = 1'b1;
      #20;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // last byte gets a no acknowledge so the slave lets go of the wire
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

/* File: verif/tb.sv */
// testbench for the smbus register access slave
// assumes a pull-up on the data wire and a short download count
`timescale 1ns/1ps
module tb;
   logic       clk_in;
   logic       rst_b_in;
   logic       scl;
   logic       sda_m;
   logic       sda_wire;
   logic       sda_dv;
   logic       sda_oe;
   logic       done;
   logic       a_hi;
   logic       a_lo;
   logic       ok;
   logic [1:0] sel;
   logic [8:0] seq_addr;
   logic [7:0] seq_data;
   int         bad_count;
   int         n_checks;

   smbus_register_access_slave #(.DOWNLOAD_CYCLES(300)) u_smbus_register_access_slave
   (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_dv), .sda_oe_out(sda_oe), .address_select_high_pin_in(a_hi),
      .address_select_low_pin_in(a_lo), .state_sequencer_addr_in(seq_addr),
      .state_sequencer_data_out(seq_data), .download_done_out(done)
   );
   smbus_master_model u_smbus_master_model (.sda_in(sda_wire), .scl_out(scl), .sda_out(sda_m));
   assign sda_wire = sda_m & (~sda_oe | sda_dv);

   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] q[$], output logic all_ack);
      logic ak;
      u_smbus_master_model.start_c();
      u_smbus_master_model.wbyte({smbus_slave_pkg::SLAVE_ADDR_FIXED, sel, 1'b0}, all_ack);
      foreach (q[i])
      begin
         u_smbus_master_model.wbyte(q[i], ak);
         all_ack = all_ack & ak;
      end
      u_smbus_master_model.stop_c();
   endtask

   // pointer is always set by a write first, reads carry no command
   task automatic rd(input logic [7:0] q[$], input logic [7:0] exp);
      logic [7:0] d;
      logic       ak;
      wr(q, ak);
      u_smbus_master_model.start_c();
      u_smbus_master_model.wbyte({smbus_slave_pkg::SLAVE_ADDR_FIXED, sel, 1'b1}, ak);
      u_smbus_master_model.rbyte(1'b1, d);
      u_smbus_master_model.stop_c();
      chk("read", exp, d);
   endtask

   task automatic wait_done();
      for (int i = 0; i < 1000; i++)
      begin
         if (done === 1'b1)
            return;
         @(posedge clk_in);
      end
      chk("download_done", 8'h01, 8'h00);
      test_done();
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      bad_count = 0;
      n_checks = 0;
      rst_b_in = 1'b0;
      a_hi = 1'b0;
      a_lo = 1'b0;
      sel = 2'b00;
      seq_addr = 9'h000;
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      chk("done_low", 8'h00, {7'h00, done});
      wr('{8'h10}, ok);
      chk("early_ack", 8'h00, {7'h00, ok});
      wait_done();
      $display("test startup done");
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clk_in);
         {a_hi, a_lo} <= 2'(s);
         sel = 2'(s);
         repeat (4) @(posedge clk_in);
         wr('{8'h10, 8'h55 + 8'(s)}, ok);
         chk("addr_ack", 8'h01, {7'h00, ok});
         sel = 2'(s) ^ 2'b01;
         wr('{8'h10, 8'h99}, ok);
         chk("addr_nack", 8'h00, {7'h00, ok});
         sel = 2'(s);
      end
      rd('{8'h10}, 8'h58);
      $display("test addressing done");
      wr('{8'hf4, 8'h00}, ok);
      rd('{smbus_slave_pkg::MAKER_OFS}, smbus_slave_pkg::MAKER_VALUE);
      rd('{smbus_slave_pkg::REVISION_OFS}, smbus_slave_pkg::REVISION_VALUE);
      rd('{smbus_slave_pkg::BRAND_FIRST_OFS}, smbus_slave_pkg::BRAND_FIRST_VALUE);
      rd('{smbus_slave_pkg::BRAND_SECOND_OFS}, smbus_slave_pkg::BRAND_SECOND_VALUE);
      $display("test identification done");
      wr('{8'hf8, 8'h05, 8'ha5}, ok);
      wr('{8'hf8, 8'h05, 8'h5a}, ok);
      rd('{8'hf8, 8'h05}, 8'ha5);
      wr('{8'hf8, 8'he0, 8'h12}, ok);
      rd('{8'hf8, 8'he0}, 8'hff);
      wr('{8'hf9, 8'h00, 8'h34}, ok);
      rd('{8'hf9, 8'h00}, 8'h34);
      $display("test eeprom done");
      wr('{8'h05, 8'h00}, ok);
      rd('{8'h05}, 8'h00);
      wr('{8'hd8, 8'h01}, ok);
      wait_done();
      rd('{8'h05}, 8'ha5);
      $display("test reload done");
      wr('{8'hfa, 8'h03, 8'h3c}, ok);
      @(posedge clk_in);
      seq_addr <= 9'h003;
      repeat (2) @(posedge clk_in);
      chk("state_cell", 8'h3c, seq_data);
      wr('{8'h20}, ok);
      wr('{smbus_slave_pkg::BLOCK_WRITE_CMD, 8'h02, 8'h11, 8'h22}, ok);
      rd('{8'h20}, 8'h11);
      rd('{8'h21}, 8'h22);
      $display("test block done");
      test_done();
   end
endmodule
